// ==== hw/mem_fault_status_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module mem_fault_status_flags (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [11:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic [31:0]                     hrdata,
  output logic                            hreadyout,
  output logic [1:0]                      hresp,
  // core fault events
  input  wire mem_fault_pkg::fault_event_t fault_in,
  // actions toward core and interrupt
  output mem_fault_pkg::fault_action_t    action_out,
  output logic                            irq
);
  import mem_fault_pkg::*;

  // ************************************************
  // state
  // ************************************************
  // every register below freezes while clk_en is low, so a stalled
  // core never loses a flag and never sees a flag appear out of turn
  // status flags are set by hardware and cleared only by software
  logic [7:0]  status_q, status_d;   // sticky fault flags
  logic [7:0]  mask_q;               // interrupt enables
  logic [31:0] addr_q;               // fault address capture
  logic [31:0] hrdata_q;             // read data register
  logic        irq_q;                // interrupt register
  fault_action_t act_q, act_d;       // action register
  logic        wr_pend_q;            // write data phase pending
  logic [11:0] wr_addr_q;            // latched write address

  // ************************************************
  // bus decode
  // ************************************************
  wire         take     = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire         take_rd  = take && !hwrite;
  // register select, shared by the write and the read decode
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
    // full compare, so aliases of a register never hit
    return a == off;
  endfunction

  // write strobes act in the data phase, on the latched address
  wire         wr_stat  = wr_pend_q && reg_hit(wr_addr_q, STATUS_OFFSET);
  wire         wr_mask  = wr_pend_q && reg_hit(wr_addr_q, MASK_OFFSET);
  // write one to clear, zeros and reserved positions do nothing
  wire [7:0]   w1c      = wr_stat ? (hwdata[7:0] & IMPL_BITS) : 8'h00;
  // read selects use the address phase address
  wire         rd_stat  = reg_hit(haddr, STATUS_OFFSET);
  wire         rd_mask  = reg_hit(haddr, MASK_OFFSET);
  wire         rd_addr  = reg_hit(haddr, ADDR_OFFSET);
  // read mux, unmapped reads as zero
  wire [31:0]  rd_mux   = rd_stat ? {24'h00_0000, status_q & IMPL_BITS} :
                          rd_mask ? {24'h00_0000, mask_q & IMPL_BITS} :
                          rd_addr ? addr_q : 32'h0000_0000;

  // ************************************************
  // fault classification
  // ************************************************
  // execute-never hit faults regardless of protection unit state
  wire         instr_ev = fault_in.instr_fault || fault_in.exec_never_hit;
  // only a data violation captures an address
  wire         cap_ev   = fault_in.data_fault;
  wire [7:0]   set_v;
  assign set_v[BIT_ADDR_VALID] = cap_ev;
  assign set_v[6:5]            = 2'b00;
  assign set_v[BIT_STACK]      = fault_in.stack_fault;
  assign set_v[BIT_UNSTACK]    = fault_in.unstack_fault;
  assign set_v[2]              = 1'b0;
  assign set_v[BIT_DATA]       = fault_in.data_fault;
  assign set_v[BIT_INSTR]      = instr_ev;

  // next flags: set wins over clear, zero writes keep value
  always_comb begin
    status_d = ((status_q & ~w1c) | set_v) & IMPL_BITS;
  end

  // action directives for the core
  always_comb begin
    act_d.adjust_sp = fault_in.stack_fault;
    act_d.chain     = fault_in.unstack_fault;
    act_d.stack_pc  = fault_in.data_fault || instr_ev;
  end

  // ************************************************
  // registers
  // ************************************************
  // flag, mask and capture storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= STATUS_RESET;
      mask_q   <= MASK_RESET;
      addr_q   <= ADDR_RESET;
    end else if (clk_en) begin
      status_q <= status_d;
      if (wr_mask) begin
        mask_q <= hwdata[7:0] & IMPL_BITS;
      end
      if (cap_ev) begin
        addr_q <= fault_in.data_addr;
      end
    end
  end

  // bus phase tracking and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr;
      if (take_rd) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // interrupt and action outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
      act_q <= '0;
    end else if (clk_en) begin
      irq_q <= |(status_d & mask_q);
      act_q <= act_d;
    end
  end

  // ************************************************
  // bus response outputs
  // ************************************************
  logic        hready_q;             // ready output register
  logic [1:0]  hresp_q;              // response output register

  // zero wait states: ready stands high out of reset, reply always okay
  // kept in flops so that every top-level output leaves a register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // ready high even in reset, so a master is never stalled
      hready_q <= 1'b1;
      hresp_q  <= HRESP_OKAY;
    end else if (clk_en) begin
      // no error path exists in this block
      hready_q <= 1'b1;
      hresp_q  <= HRESP_OKAY;
    end
  end

  // ************************************************
  // output wiring
  // ************************************************
  // every output below comes straight from a register
  assign hrdata     = hrdata_q;
  assign hreadyout  = hready_q;
  assign hresp      = hresp_q;
  assign irq        = irq_q;
  assign action_out = act_q;

  // ************************************************
  // checks
  // ************************************************
  stack_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.stack_fault |=> status_q[BIT_STACK])
    else $error("stacking flag not set");
  unstack_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.unstack_fault |=> status_q[BIT_UNSTACK] && action_out.chain)
    else $error("unstacking flag or chain missing");
  data_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.data_fault |=> addr_q == $past(fault_in.data_addr) && status_q[BIT_ADDR_VALID])
    else $error("data fault address not captured");
  instr_nocap_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !fault_in.data_fault |=> $stable(addr_q))
    else $error("capture changed without data fault");
  exec_never_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.exec_never_hit |=> status_q[BIT_INSTR] && action_out.stack_pc)
    else $error("execute-never fetch not flagged");
  sticky_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    status_q[BIT_DATA] && !(clk_en && wr_stat && hwdata[BIT_DATA]) |=> status_q[BIT_DATA])
    else $error("data flag dropped without clear");
  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    status_q[6:5] == 2'b00 && status_q[2] == 1'b0)
    else $error("reserved bit set");
  irq_follows_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en |=> irq == |($past(status_d) & $past(mask_q)))
    else $error("interrupt mismatch");
  stack_sp_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.stack_fault && !fault_in.data_fault |=> action_out.adjust_sp && $stable(addr_q))
    else $error("stacking fault action wrong");

  // ************************************************
  // further checks on flags, capture and bus
  // ************************************************
  // a data violation with clk_en high always raises its flag
  data_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.data_fault |=> status_q[BIT_DATA])
    else $error("data flag not set");

  // a plain fetch violation raises bit 0 and the stacked pc directive
  instr_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.instr_fault |=> status_q[BIT_INSTR] && action_out.stack_pc)
    else $error("fetch flag not set");

  // unstacking chains without moving sp or capturing an address
  unstack_nocap_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && fault_in.unstack_fault && !fault_in.data_fault && !fault_in.stack_fault
    |=> $stable(addr_q) && !action_out.adjust_sp)
    else $error("unstacking fault moved sp or captured");

  // a lone fetch fault neither captures nor moves sp
  instr_only_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && instr_ev && !fault_in.data_fault && !fault_in.stack_fault && !fault_in.unstack_fault
    |=> $stable(addr_q) && !action_out.adjust_sp && !action_out.chain)
    else $error("fetch fault action wrong");

  // valid flag only appears with a captured data address
  valid_source_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !fault_in.data_fault && !status_q[BIT_ADDR_VALID] |=> !status_q[BIT_ADDR_VALID])
    else $error("address valid set without capture");

  // a written one clears its flag when no new event arrives
  w1c_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && wr_stat && hwdata[BIT_INSTR] && !instr_ev |=> !status_q[BIT_INSTR])
    else $error("write one did not clear");

  // an event in the clearing cycle wins
  set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && wr_stat && hwdata[BIT_DATA] && fault_in.data_fault |=> status_q[BIT_DATA])
    else $error("clear beat a new event");

  // a written zero leaves its flag alone
  zero_write_keeps_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && wr_stat && !hwdata[BIT_STACK] && status_q[BIT_STACK] |=> status_q[BIT_STACK])
    else $error("zero write dropped a flag");

  // a low clock enable freezes flags, mask, capture and read data
  freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |=> $stable(status_q) && $stable(mask_q) && $stable(addr_q) && $stable(hrdata))
    else $error("state moved while frozen");

  // status reads show zero in reserved and upper positions
  reserved_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && take_rd && rd_stat
    |=> hrdata[31:8] == 24'h00_0000 && hrdata[6:5] == 2'b00 && hrdata[2] == 1'b0)
    else $error("reserved bit read as one");

  // mask keeps only implemented positions
  mask_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && wr_mask |=> mask_q == ($past(hwdata[7:0]) & IMPL_BITS))
    else $error("mask write wrong");

  // no unmasked flag, no interrupt
  irq_masked_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && ((status_d & mask_q) == 8'h00) |=> !irq)
    else $error("interrupt without unmasked flag");
endmodule
`default_nettype wire

// ==== shared/mem_fault_pkg.sv ====
//
// Behaviour
// - address valid flag tracks captured address
// - flags sticky until written with one
// - bits 6:5 and 2 read zero
// - stacking fault sets bit 4
// - stacking fault adjusts sp, no capture
// - unstacking fault sets bit 3
// - unstacking fault chains, no sp change, no capture
// - data access fault sets bit 1
// - data fault stacks pc, captures address
// - fetch from no-execute location sets bit 0
// - execute-never region faults even without protection
// - fetch fault stacks pc, no capture
`default_nettype none
package mem_fault_pkg;
  // ************************************************
  // register map
  // ************************************************
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] MASK_OFFSET   = 12'h004;
  localparam logic [11:0] ADDR_OFFSET   = 12'h008;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  // ************************************************
  // field positions
  // ************************************************
  localparam int BIT_ADDR_VALID = 7;
  localparam int BIT_STACK      = 4;
  localparam int BIT_UNSTACK    = 3;
  localparam int BIT_DATA       = 1;
  localparam int BIT_INSTR      = 0;
  localparam logic [7:0] IMPL_BITS = 8'h9B;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY    = 2'b00;
  // fault events reported by the core in one cycle
  typedef struct packed {
    logic        stack_fault;     // context save violation
    logic        unstack_fault;   // context restore violation
    logic        data_fault;      // load or store violation
    logic        instr_fault;     // fetch from non-executable location
    logic        exec_never_hit;  // fetch from execute-never region
    logic [31:0] data_addr;       // address of violating data access
  } fault_event_t;
  // directives back to the core exception logic
  typedef struct packed {
    logic adjust_sp;    // stack pointer still adjusted
    logic chain;        // chain into handler, keep return stack
    logic stack_pc;     // stacked pc points at faulting instruction
  } fault_action_t;
endpackage
`default_nettype wire

// ==== verification/fault_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fault_core_model
  import mem_fault_pkg::*;
(
  // core clock and fault events
  input  wire logic                        clk,
  output var mem_fault_pkg::fault_event_t fault_in
);
  logic busy = 1'b0;  // pulse in flight
  initial fault_in = '0;
  // idle address lines toggle so that a stale address never looks captured
  always @(posedge clk) if (!busy) fault_in.data_addr <= ~fault_in.data_addr;
  // one-cycle pulse: 0 stack, 1 unstack, 2 data, 3 fetch, 4 execute-never
  task automatic raise(input int k, input logic [31:0] a);
    busy = 1'b1;
    fault_in <= {k == 0, k == 1, k == 2, k == 3, k == 4, a};
    @(posedge clk);
    fault_in <= {5'b0_0000, ~a};
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mem_fault_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rd, a, cap;
  logic [1:0] hresp;
  wire logic hready_w;
  fault_event_t fault_in;
  fault_action_t act;
  logic irq;
  int err_count = 0, cmp_count = 0;
  mem_fault_status_flags mem_fault_status_flags_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready_w), .hrdata(hrdata), .hreadyout(hready_w), .hresp(hresp), .fault_in(fault_in),
    .action_out(act), .irq(irq));
  fault_core_model fault_core_model_i (.clk(clk), .fault_in(fault_in));
  initial forever #2.5 clk = ~clk;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    hsel <= 1; haddr <= ad; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge clk); while (hready_w !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk); while (hready_w !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input string n, input logic [11:0] ad, input logic [31:0] e);
    bus(0, ad, '0);
    check(n, rd, e);
  endtask
  // expected status bits and core action for each fault kind
  function automatic logic [31:0] exp_bits(input int k);
    return k == 0 ? 32'h0000_0010 : k == 1 ? 32'h0000_0008 : k == 2 ? 32'h0000_0082 : 32'h0000_0001;
  endfunction
  function automatic logic [2:0] exp_act(input int k);
    return k == 0 ? 3'b100 : k == 1 ? 3'b010 : 3'b001;
  endfunction
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hbe20));
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rdchk("status", STATUS_OFFSET, 32'h0000_0000);
    rdchk("mask", MASK_OFFSET, 32'h0000_0000);
    rdchk("addr", ADDR_OFFSET, 32'h0000_0000);
    rdchk("unmapped", 12'h010, 32'h0000_0000);
    check("hresp", {30'h0, hresp}, 32'h0000_0000);
    cap = '0;
    for (int k = 0; k < 5; k++) begin
      a = $urandom;
      fault_core_model_i.raise(k, a);
      #1;
      check("action", {29'h0, act}, {29'h0, exp_act(k)});
      @(posedge clk);
      if (k == 2) cap = a;
      rdchk("status", STATUS_OFFSET, exp_bits(k));
      rdchk("addr", ADDR_OFFSET, cap);
      bus(1, STATUS_OFFSET, 32'h0000_0000);
      rdchk("keep", STATUS_OFFSET, exp_bits(k));
      bus(1, STATUS_OFFSET, 32'hFFFF_FFFF);
      rdchk("clear", STATUS_OFFSET, 32'h0000_0000);
      $display("fault kind %0d done", k);
    end
    bus(1, MASK_OFFSET, 32'hFFFF_FFFF);
    rdchk("mask", MASK_OFFSET, 32'h0000_009B);
    cap = $urandom;
    fault_core_model_i.raise(2, cap);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    bus(1, STATUS_OFFSET, 32'h0000_0002);
    rdchk("w1c", STATUS_OFFSET, 32'h0000_0080);
    // escalated-fault handler clears the valid flag
    bus(1, STATUS_OFFSET, 32'h0000_0080);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    bus(1, MASK_OFFSET, 32'h0000_0000);
    fault_core_model_i.raise(3, $urandom);
    repeat (2) @(posedge clk);
    check("masked", {31'h0, irq}, 32'h0000_0000);
    rdchk("status", STATUS_OFFSET, 32'h0000_0001);
    $display("interrupt test done");
    // frozen clock enable: a fault pulse must leave no trace
    clk_en <= 0;
    fault_core_model_i.raise(2, $urandom);
    clk_en <= 1;
    rdchk("frozen", STATUS_OFFSET, 32'h0000_0001);
    rdchk("frozen addr", ADDR_OFFSET, cap);
    $display("freeze test done");
    finish_test();
  end
endmodule
`default_nettype wire
